// >>> include/adctc_core_if.sv
`default_nettype none
interface adctc_core_if;
  logic [31:0] src;
  adctc_pkg::adctc_code_t sel;
  logic trig;
  logic load;
  adctc_pkg::adctc_count_t load_val;
  logic expire;
  modport mux (input src, input sel, output trig);
  modport ctl (output src, output sel, input trig, output load, output load_val, input expire);
  modport tmr (input load, input load_val, output expire);
endinterface : adctc_core_if
`default_nettype wire

// >>> include/adctc_map.svh
`ifndef ADCTC_MAP_SVH
`define ADCTC_MAP_SVH

// APB byte offsets
`define ADCTC_OFF_CTRL 8'h00
`define ADCTC_OFF_TRIG 8'h04
`define ADCTC_OFF_CHAN 8'h08
`define ADCTC_OFF_ACQ 8'h0c
`define ADCTC_OFF_PRE 8'h10
`define ADCTC_OFF_RES_LO 8'h14
`define ADCTC_OFF_RES_HI 8'h18
`define ADCTC_OFF_ERR_HI 8'h1c
`define ADCTC_OFF_STAT 8'h20
`define ADCTC_OFF_ICLR 8'h24
`define ADCTC_OFF_IEN 8'h28
`define ADCTC_OFF_PINMAP 8'h2c

// Control and status bit positions
`define ADCTC_CTRL_ON 0
`define ADCTC_CTRL_GO 1
`define ADCTC_CTRL_CONTINUOUS_ENABLE 2
`define ADCTC_ST_DONE 0
`define ADCTC_ST_IGN 1

// Trigger selector codes
`define ADCTC_CODE_OFF 5'h00
`define ADCTC_CODE_PIN 5'h01
`define ADCTC_CODE_IOC 5'h13
`define ADCTC_CODE_ERRRD 5'h1c
`define ADCTC_CODE_RESRD 5'h1d
`define ADCTC_CODE_CHWR 5'h1f

// Counts and reset values
`define ADCTC_ACQ_MAX 13'h1fff
`define ADCTC_RST_CODE 5'h00
`define ADCTC_RST_CHAN 6'h00
`define ADCTC_RST_CNT 13'h0000
`define ADCTC_RST_PIN 3'h0

`endif

// >>> include/adctc_pkg.sv
`default_nettype none
package adctc_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_pre = 2'b01,
    st_acq = 2'b10,
    st_conv = 2'b11
  } adctc_state_e;
  typedef logic [12:0] adctc_count_t;
  typedef logic [4:0] adctc_code_t;
endpackage : adctc_pkg
`default_nettype wire

// >>> rtl/adctc_phase_timer.sv
`default_nettype none
`include "adctc_map.svh"
module adctc_phase_timer (
  input wire logic clock, // System clock
  input wire logic reset_n, // Sync reset, active low
  adctc_core_if.tmr core // Load and expiry
);
  adctc_pkg::adctc_count_t cnt_r;
  logic expire_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_r <= `ADCTC_RST_CNT;
      expire_r <= 1'b0;
    end else begin
      cnt_r <= core.load ? core.load_val :
               (cnt_r != 13'h0000) ? cnt_r - 13'h0001 : cnt_r;
      // A reload cancels a pending expiry
      expire_r <= (cnt_r == 13'h0001) & ~core.load;
    end
  end

  assign core.expire = expire_r;
endmodule : adctc_phase_timer
`default_nettype wire

// >>> rtl/adctc_top.sv
`default_nettype none
// Summary of operation
// RQ1: Code 11111 triggers on every software write of the channel select register.
// RQ2: Code 11101 triggers on every software read of the result high byte.
// RQ3: Code 11100 triggers on every software read of the error high byte.
// RQ4: Software never programs code 11110 or 11000 to 11011; they are reserved.
// RQ5: Code 00001 takes the mapped trigger pin; code 00000 disables triggering.
// RQ6: Codes 00010 to 10111 select timers, captures, PWMs, oscillator, comparators, cells.
// RQ7: A rising edge of the selected source sets the go bit.
// RQ8: Software turns the module on first, never with go in that write.
// RQ9: With acquisition count zero, software waits the acquisition time itself.
// RQ10: Precharge and acquisition counts both zero: conversion starts without acquisition delay.
// RQ11: Software starts a conversion by writing one to go.
// RQ12: Completion is seen by go clearing, the done flag, or the interrupt.
// RQ13: Conversion end clears go unless continuous, and sets the done flag.
// RQ14: Software clears the done flag after reading the result.
// RQ15: A channel change restarts a full acquisition before conversion.
// RQ16: Software may keep global interrupts off to resume in line after wake.
// RQ17: Register-access sources pulse once per access; all sources are edge-detected.
// RQ18: A trigger edge during a conversion is dropped, not queued.
`include "adctc_map.svh"
module adctc_top (
  input wire logic clock, // System clock, 125 MHz
  input wire logic reset_n, // Sync reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [6:0] timer_events, // Timer 0..6 overflow or postscaled
  input wire logic signal_timer_trigger, // Signal timer trigger
  input wire logic [3:0] capture_compare_triggers, // Capture/compare 1..4
  input wire logic [1:0] pwm_outputs, // PWM 6 and 7
  input wire logic numeric_osc_output, // Numeric oscillator
  input wire logic [1:0] comparator_outputs, // Comparators 1 and 2
  input wire logic [7:0] ioc_flags, // Pin-change flags
  input wire logic [3:0] logic_cell_outputs, // Logic cells 1..4
  input wire logic [7:0] trigger_pins, // Remappable trigger pins
  input wire logic convert_done, // Converter finished, one cycle
  input wire logic [11:0] result_data, // Converter result
  input wire logic [15:0] error_data, // Computed error
  output logic [5:0] channel_sel, // Analog channel
  output logic precharge_active, // Precharge phase
  output logic acquire_active, // Acquisition phase
  output logic convert_active, // Conversion phase
  output logic irq // Level interrupt
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic on_r;
  logic continuous_enable_r;
  logic go_r;
  adctc_pkg::adctc_code_t trig_sel_r;
  logic [5:0] chan_r;
  adctc_pkg::adctc_count_t acq_r;
  adctc_pkg::adctc_count_t pre_r;
  logic [2:0] pin_map_r;
  logic [11:0] res_r;
  logic [15:0] err_r;
  logic [1:0] status_r;
  logic [1:0] inten_r;
  logic irq_r;
  adctc_pkg::adctc_state_e state_r;
  adctc_pkg::adctc_state_e state_nxt;
  logic [1:0] status_nxt;
  // Phase flags follow the next state, so the pins come from flops
  logic pre_act_r;
  logic acq_act_r;
  logic conv_act_r;

  adctc_core_if core ();

  adctc_trig_mux u_mux (
    .clock(clock),
    .reset_n(reset_n),
    .core(core.mux)
  );

  adctc_phase_timer u_timer (
    .clock(clock),
    .reset_n(reset_n),
    .core(core.tmr)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire access = psel & penable;
  wire commit = access & pready_r;
  wire wr_commit = commit & pwrite;
  wire rd_commit = commit & ~pwrite;
  wire first = access & ~pready_r;
  wire hit_ctrl = (paddr == `ADCTC_OFF_CTRL);
  wire hit_trig = (paddr == `ADCTC_OFF_TRIG);
  wire hit_chan = (paddr == `ADCTC_OFF_CHAN);
  wire hit_acq = (paddr == `ADCTC_OFF_ACQ);
  wire hit_pre = (paddr == `ADCTC_OFF_PRE);
  wire hit_res_lo = (paddr == `ADCTC_OFF_RES_LO);
  wire hit_res_hi = (paddr == `ADCTC_OFF_RES_HI);
  wire hit_err_hi = (paddr == `ADCTC_OFF_ERR_HI);
  wire hit_stat = (paddr == `ADCTC_OFF_STAT);
  wire hit_iclr = (paddr == `ADCTC_OFF_ICLR);
  wire hit_ien = (paddr == `ADCTC_OFF_IEN);
  wire hit_pin = (paddr == `ADCTC_OFF_PINMAP);
  wire addr_ok = hit_ctrl | hit_trig | hit_chan | hit_acq | hit_pre | hit_res_lo |
                 hit_res_hi | hit_err_hi | hit_stat | hit_iclr | hit_ien | hit_pin;

  wire [31:0] rd_word =
    hit_ctrl ? {29'h0, continuous_enable_r, go_r, on_r} :
    hit_trig ? {27'h0, trig_sel_r} :
    hit_chan ? {26'h0, chan_r} :
    hit_acq ? {19'h0, acq_r} :
    hit_pre ? {19'h0, pre_r} :
    hit_res_lo ? {24'h0, res_r[7:0]} :
    hit_res_hi ? {28'h0, res_r[11:8]} :
    hit_err_hi ? {24'h0, err_r[15:8]} :
    hit_stat ? {30'h0, status_r} :
    hit_ien ? {30'h0, inten_r} :
    hit_pin ? {29'h0, pin_map_r} : 32'h00000000;

  wire wr_ctrl = wr_commit & hit_ctrl;
  wire wr_chan = wr_commit & hit_chan;

  //////////////////////////////////////////////////////////////////////////////
  // Trigger sources

  wire chan_wr_pulse = wr_chan; // [RQ1] [RQ17]
  wire res_rd_pulse = rd_commit & hit_res_hi; // [RQ2] [RQ17]
  wire err_rd_pulse = rd_commit & hit_err_hi; // [RQ3] [RQ17]
  wire pin_src = trigger_pins[pin_map_r]; // [RQ5]
  wire ioc_any = |ioc_flags; // [RQ6]

  // Reserved codes read a constant low, so they can never fire
  assign core.src = {chan_wr_pulse, 1'b0, res_rd_pulse, err_rd_pulse, 4'h0,
                     logic_cell_outputs, ioc_any, comparator_outputs,
                     numeric_osc_output, pwm_outputs, capture_compare_triggers,
                     signal_timer_trigger, timer_events, pin_src, 1'b0}; // [RQ6] [RQ4]
  assign core.sel = trig_sel_r;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing

  wire idle = (state_r == adctc_pkg::st_idle);
  // On must already be set; a write turning it on cannot also start
  wire sw_go = wr_ctrl & pwdata[`ADCTC_CTRL_GO] & on_r; // [RQ8] [RQ11]
  wire hw_go = core.trig & on_r; // [RQ7]
  wire start = (sw_go | hw_go) & idle;
  wire dropped = hw_go & ~idle; // [RQ18]
  wire abort = ~idle & wr_ctrl & (~pwdata[`ADCTC_CTRL_GO] | ~pwdata[`ADCTC_CTRL_ON]);
  wire conv_end = (state_r == adctc_pkg::st_conv) & convert_done;
  wire pre_zero = (pre_r == `ADCTC_RST_CNT);
  wire acq_zero = (acq_r == `ADCTC_RST_CNT);
  // Zero acquisition means the longest wait once precharge is in use
  wire [12:0] acq_load = ~acq_zero ? acq_r : pre_zero ? `ADCTC_RST_CNT : `ADCTC_ACQ_MAX;

  // First phase of a new conversion, shared by start and continuous restart
  adctc_pkg::adctc_state_e first_st;
  assign first_st = ~pre_zero ? adctc_pkg::st_pre :
                    ~acq_zero ? adctc_pkg::st_acq : adctc_pkg::st_conv; // [RQ10]
  wire [12:0] first_load = ~pre_zero ? pre_r : acq_r;
  wire first_timed = first_st != adctc_pkg::st_conv;

  always_comb begin
    state_nxt = state_r;
    core.load = 1'b0;
    core.load_val = acq_load;
    case (state_r)
      adctc_pkg::st_idle: begin
        if (start) begin
          state_nxt = first_st;
          core.load = first_timed;
          core.load_val = first_load;
        end
      end
      adctc_pkg::st_pre: begin
        if (core.expire) begin
          state_nxt = acq_zero & pre_zero ? adctc_pkg::st_conv : adctc_pkg::st_acq;
          core.load = 1'b1;
        end
      end
      adctc_pkg::st_acq: begin
        if (wr_chan) begin
          core.load = 1'b1; // [RQ15]
        end else if (core.expire) begin
          state_nxt = adctc_pkg::st_conv;
        end
      end
      adctc_pkg::st_conv: begin
        if (convert_done) begin
          // Continuous mode retriggers without software
          state_nxt = continuous_enable_r ? first_st : adctc_pkg::st_idle; // [RQ13]
          core.load = continuous_enable_r & first_timed;
          core.load_val = first_load;
        end
      end
      default: begin
        state_nxt = adctc_pkg::st_idle;
      end
    endcase
    if (abort) begin
      state_nxt = adctc_pkg::st_idle;
      core.load = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status and interrupt

  always_comb begin
    status_nxt = status_r;
    if (wr_commit & hit_iclr) begin
      status_nxt = status_r & ~pwdata[1:0]; // [RQ14]
    end
    // Set wins over a clear in the same cycle
    if (conv_end) begin
      status_nxt[`ADCTC_ST_DONE] = 1'b1; // [RQ13] [RQ12]
    end
    if (dropped) begin
      status_nxt[`ADCTC_ST_IGN] = 1'b1; // [RQ18]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flops

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= first;
      pslverr_r <= first & ~addr_ok;
      prdata_r <= (first & ~pwrite) ? rd_word : 32'h00000000;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      on_r <= 1'b0;
      continuous_enable_r <= 1'b0;
      trig_sel_r <= `ADCTC_RST_CODE;
      chan_r <= `ADCTC_RST_CHAN;
      acq_r <= `ADCTC_RST_CNT;
      pre_r <= `ADCTC_RST_CNT;
      pin_map_r <= `ADCTC_RST_PIN;
      inten_r <= 2'h0;
    end else if (wr_commit) begin
      if (hit_ctrl) begin
        on_r <= pwdata[`ADCTC_CTRL_ON];
        continuous_enable_r <= pwdata[`ADCTC_CTRL_CONTINUOUS_ENABLE];
      end
      if (hit_trig) trig_sel_r <= pwdata[4:0];
      if (hit_chan) chan_r <= pwdata[5:0];
      if (hit_acq) acq_r <= pwdata[12:0];
      if (hit_pre) pre_r <= pwdata[12:0];
      if (hit_pin) pin_map_r <= pwdata[2:0];
      if (hit_ien) inten_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_r <= adctc_pkg::st_idle;
      go_r <= 1'b0;
      pre_act_r <= 1'b0;
      acq_act_r <= 1'b0;
      conv_act_r <= 1'b0;
      status_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      go_r <= (state_nxt != adctc_pkg::st_idle); // [RQ7] [RQ13] [RQ12]
      pre_act_r <= (state_nxt == adctc_pkg::st_pre);
      acq_act_r <= (state_nxt == adctc_pkg::st_acq); // [RQ15]
      conv_act_r <= (state_nxt == adctc_pkg::st_conv);
      status_r <= status_nxt;
      irq_r <= |(status_nxt & inten_r); // [RQ12]
    end
  end

  // An abort still keeps the partial sample
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      res_r <= 12'h000;
      err_r <= 16'h0000;
    end else if (conv_end | (abort & (state_r == adctc_pkg::st_conv))) begin
      res_r <= result_data;
      err_r <= error_data;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign channel_sel = chan_r;
  assign precharge_active = pre_act_r;
  assign acquire_active = acq_act_r;
  assign convert_active = conv_act_r;
  assign irq = irq_r;

endmodule : adctc_top
`default_nettype wire

// >>> rtl/adctc_trig_mux.sv
`default_nettype none
`include "adctc_map.svh"
module adctc_trig_mux (
  input wire logic clock, // System clock
  input wire logic reset_n, // Sync reset, active low
  adctc_core_if.mux core // Sources, selector, trigger
);
  logic [31:0] prev_r;
  logic [31:0] rise;
  logic trig_r;

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_edge
      assign rise[i] = core.src[i] & ~prev_r[i]; // [RQ17]
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prev_r <= 32'h00000000;
      trig_r <= 1'b0;
    end else begin
      prev_r <= core.src;
      // Code zero never fires
      trig_r <= rise[core.sel] & (core.sel != `ADCTC_CODE_OFF); // [RQ5] [RQ7]
    end
  end

  assign core.trig = trig_r;
endmodule : adctc_trig_mux
`default_nettype wire

// >>> testbench/adctc_conv_model.sv
`default_nettype none
module adctc_conv_model (
  input wire logic clock, // Clock
  input wire logic reset_n, // Reset
  input wire logic convert_active, // Conversion phase
  input wire logic slow, // Long conversion
  output logic convert_done, // Done pulse
  output logic [11:0] result_data, // Result
  output logic [15:0] error_data // Error
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] res_val = 12'ha5c;
  localparam logic [15:0] err_val = 16'hc3e1;
  logic [4:0] cnt_r;
  // Reload on done too, so a continuous restart gets a full conversion
  always_ff @(posedge clock) begin
    if (!reset_n || !convert_active || convert_done) begin
      cnt_r <= slow ? 5'h14 : 5'h02;
      convert_done <= 1'b0;
    end else begin
      cnt_r <= cnt_r - 5'h01;
      convert_done <= (cnt_r == 5'h01);
    end
  end
  // Outside the done cycle the data lines show the inverse, never stale values
  assign result_data = convert_done ? res_val : ~res_val;
  assign error_data = convert_done ? err_val : ~err_val;
endmodule : adctc_conv_model
`default_nettype wire

// >>> testbench/adctc_sva.sv
`default_nettype none
module adctc_sva (
  input wire logic clock, // Clock
  input wire logic reset_n, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic convert_done, // Converter done
  input wire logic precharge_active, // Phase
  input wire logic acquire_active, // Phase
  input wire logic convert_active // Phase
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] code_r;
  logic on_r;
  logic continuous_enable_r;
  logic pz_r;
  logic az_r;
  wire wr = psel && penable && pready && pwrite;
  wire rd = psel && penable && pready && !pwrite;
  wire busy = precharge_active || acquire_active || convert_active;
  wire idle_on = on_r && !busy;
  // Shadow of the control fields, so triggers can be judged from the bus alone
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      code_r <= 5'h00;
      on_r <= 1'b0;
      continuous_enable_r <= 1'b0;
      pz_r <= 1'b1;
      az_r <= 1'b1;
    end else if (wr) begin
      if (paddr == 8'h00) on_r <= pwdata[0];
      if (paddr == 8'h00) continuous_enable_r <= pwdata[2];
      if (paddr == 8'h04) code_r <= pwdata[4:0];
      if (paddr == 8'h0c) az_r <= (pwdata[12:0] == 13'h0000);
      if (paddr == 8'h10) pz_r <= (pwdata[12:0] == 13'h0000);
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_time: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_phase_excl: assert property ($onehot0({precharge_active, acquire_active, convert_active}))
    else $error("two phases at once");
  a_chan_trig: assert property (wr && paddr == 8'h08 && code_r == 5'h1f && idle_on
    |-> ##[1:6] busy) else $error("channel write did not start");
  a_res_trig: assert property (rd && paddr == 8'h18 && code_r == 5'h1d && idle_on
    |-> ##[1:6] busy) else $error("result read did not start");
  a_err_trig: assert property (rd && paddr == 8'h1c && code_r == 5'h1c && idle_on
    |-> ##[1:6] busy) else $error("error read did not start");
  a_go_needs_on: assert property (wr && paddr == 8'h00 && pwdata[1] && !on_r && !busy
    |=> !busy [*6]) else $error("start while off");
  a_quick_start: assert property (wr && paddr == 8'h00 && pwdata[1:0] == 2'b11
    && idle_on && pz_r && az_r |=> convert_active) else $error("no direct conversion");
  a_done_ends: assert property (convert_active && convert_done && !continuous_enable_r && !wr
    |=> !busy) else $error("conversion kept running");
  a_continuous_enable_again: assert property (convert_active && convert_done && continuous_enable_r && on_r && !wr
    |=> busy) else $error("continuous mode stopped");
endmodule : adctc_sva

bind adctc_top adctc_sva adctc_sva_i (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .convert_done, .precharge_active, .acquire_active,
  .convert_active);
`default_nettype wire

// >>> testbench/adctc_tb.sv
`default_nettype none
module adctc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] srcs = 24'h0;
  logic [31:0] rdat;
  logic rerr;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [4:0] trig_code [3] = '{5'h1f, 5'h1d, 5'h1c};
  logic [7:0] trig_off [3] = '{8'h08, 8'h18, 8'h1c};
  wire logic [31:0] prdata;
  wire logic pready, pslverr, convert_done, precharge_active, acquire_active, convert_active, irq;
  wire logic [11:0] result_data;
  wire logic [15:0] error_data;
  wire logic [5:0] channel_sel;
  wire logic busy = precharge_active || acquire_active || convert_active;

  always #4 clock = ~clock;

  // Source bit n is trigger code n; pin map 5 picks trigger pin 5
  adctc_top adctc_top_i (
    .clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timer_events(srcs[8:2]), .signal_timer_trigger(srcs[9]),
    .capture_compare_triggers(srcs[13:10]), .pwm_outputs(srcs[15:14]),
    .numeric_osc_output(srcs[16]), .comparator_outputs(srcs[18:17]),
    .ioc_flags({srcs[19], 7'h00}), .logic_cell_outputs(srcs[23:20]),
    .trigger_pins({2'h0, srcs[1], 5'h00}), .convert_done, .result_data, .error_data,
    .channel_sel, .precharge_active, .acquire_active, .convert_active, .irq
  );
  adctc_conv_model adctc_conv_model_i (
    .clock, .reset_n, .convert_active, .slow, .convert_done, .result_data, .error_data
  );
  ////////////////////////////////////////
  task end_sim;
    $display("compares %0d, bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  // Polls go, checks status and the interrupt, then clears
  task conv_end(input logic [31:0] st);
    int n;
    n = 0;
    rdat = 32'h2;
    while (rdat[1] !== 1'b0 && n < 80) begin
      xfer(1'b0, 8'h00, 32'h0);
      n++;
    end
    chk(32'(rdat[1]), 32'h0);
    rd(8'h20, st);
    chk(32'(irq), 32'h1);
    wr(8'h24, 32'h3);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0);
  endtask : conv_end

  task wait_conv;
    int n;
    n = 0;
    while (convert_active !== 1'b1 && n < 12) begin
      @(posedge clock);
      n++;
    end
    chk(32'(convert_active), 32'h1);
  endtask : wait_conv
  ////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    for (int a = 0; a < 48; a += 4) begin
      rd(8'(a), 32'h0);
    end
    xfer(1'b0, 8'h30, 32'h0);
    chk(32'(rerr), 32'h1);
    wr(8'h00, 32'h3);
    rd(8'h00, 32'h1);
    wr(8'h28, 32'h1);
    repeat (4) @(posedge clock);
    wr(8'h00, 32'h3);
    conv_end(32'h1);
    rd(8'h18, 32'ha);
    rd(8'h14, 32'h5c);
    rd(8'h1c, 32'hc3);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, {27'h0, trig_code[i]});
      xfer(i == 0, trig_off[i], 32'h2a);
      conv_end(32'h1);
    end
    chk(32'(channel_sel), 32'h2a);
    wr(8'h2c, 32'h5);
    for (int c = 1; c < 24; c++) begin
      wr(8'h04, 32'(c));
      srcs <= 24'h1 << c;
      wait_conv();
      srcs <= 24'h0;
      conv_end(32'h1);
    end
    wr(8'h04, 32'h0);
    srcs <= 24'hfffffe;
    repeat (10) @(posedge clock);
    chk(32'(busy), 32'h0);
    srcs <= 24'h0;
    // Timer edge lands mid-conversion; it must be flagged, not replayed
    wr(8'h04, 32'h2);
    slow <= 1'b1;
    wr(8'h00, 32'h3);
    repeat (4) @(posedge clock);
    srcs <= 24'h4;
    conv_end(32'h3);
    chk(32'(busy), 32'h0);
    srcs <= 24'h0;
    wr(8'h04, 32'h0);
    wr(8'h0c, 32'ha);
    wr(8'h00, 32'h3);
    repeat (6) @(posedge clock);
    wr(8'h08, 32'h15);
    repeat (8) @(posedge clock);
    chk(32'(acquire_active), 32'h1);
    conv_end(32'h1);
    // Precharge of 4 cycles, then acquisition of 3
    wr(8'h10, 32'h3);
    wr(8'h0c, 32'h2);
    wr(8'h00, 32'h3);
    @(posedge clock);
    chk(32'(precharge_active), 32'h1);
    repeat (4) @(posedge clock);
    chk(32'(acquire_active), 32'h1);
    conv_end(32'h1);
    wr(8'h10, 32'h0);
    slow <= 1'b0;
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h7);
    while (convert_done !== 1'b1) @(posedge clock);
    repeat (2) @(posedge clock);
    chk(32'(busy), 32'h1);
    wr(8'h00, 32'h1);
    @(posedge clock);
    chk(32'(busy), 32'h0);
    wr(8'h24, 32'h3);
    end_sim();
  end
endmodule : adctc_tb
`default_nettype wire
